// ===== logic/run_halt_bus_release.sv
// run/halt control, bus release and board reset line of the processor module
//
// Behaviour
// - with run/halt high the core is allowed to fetch and execute from its program counter.
// - with run/halt low all processor activity is suspended once the instruction in flight has completed.
// - only the sampled level of run/halt decides between running and halting, never an edge.
// - a halt takes effect only at an instruction boundary, after the current instruction completes.
// - while halted bus_available is high and address_valid_strobe is low.
// - while halted the address, data and read/write drivers are all released to high impedance.
// - the reset line is two-way: internal reset is driven out and an external pull low restarts the board.
// - read/write is high for reads, low for writes, and rests high when idle or halted.
// - bus_available is also high in the wait state, which a maskable or non-maskable interrupt ends.
`timescale 1ns/1ps
module run_halt_bus_release #(
    parameter int ADDR_W = run_halt_pkg::ADDR_W,
    parameter int DATA_W = run_halt_pkg::DATA_W
) (
    input wire logic clock,
    input wire logic rst_n,
    // phase-one leading edge enable from the clock divider
    input wire logic phi1_en,
    input wire logic run_halt_pin,
    input wire logic reset_line_in,
    input wire logic power_on_reset_n,
    input wire logic irq_n_pin,
    input wire logic nmi_n_pin,
    // execution core handshake
    input wire run_halt_pkg::bus_req_t core_req,
    input wire logic core_insn_end,
    input wire logic core_wait_insn,
    input wire logic [DATA_W-1:0] data_in,
    output logic core_advance,
    output logic core_reset,
    output logic [DATA_W-1:0] core_rdata,
    output run_halt_pkg::bus_pins_t pins,
    output logic reset_line_out,
    output logic reset_line_oe
);
    // ------------------------------------------------------------
    // elaboration checks
    // ------------------------------------------------------------
    // the backplane struct is sized by the package, so the widths cannot move on their own
    if (ADDR_W != run_halt_pkg::ADDR_W) begin : g_addr_w_bad
        $error("ADDR_W must match the package bus struct");
    end
    if (DATA_W != run_halt_pkg::DATA_W) begin : g_data_w_bad
        $error("DATA_W must match the package bus struct");
    end
    // a zero stretch would let a bouncing switch restart the board several times
    if (run_halt_pkg::RESET_STRETCH == '0) begin : g_stretch_bad
        $error("RESET_STRETCH must be above zero");
    end

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        // two-stage synchronisers; only stage two is read by logic
        logic [1:0] run_sync;
        logic [1:0] rst_sync;
        logic [1:0] irq_sync;
        logic [1:0] nmi_sync;
        // run/halt level as taken at the last phase-one pulse
        logic run_level;
        run_halt_pkg::cpu_mode_t mode;
        logic [3:0] reset_cnt;
        logic board_reset;
        run_halt_pkg::bus_pins_t pins;
        logic [DATA_W-1:0] rdata;
    } state_t;

    state_t s_q;
    state_t s_d;

    logic running;
    logic bus_released;
    // a bus cycle that the core asks for and may run this cycle
    logic cycle_go;
    logic cycle_write;
    // last cycle put a read strobe on the pins, so data_in carries its answer now
    logic read_done;
    // latched halt request, synchronised wake-up and instruction boundary
    logic halt_req;
    logic wake_req;
    logic at_boundary;

    // limitation: reset_line_in must carry only the far side's pull; if it sensed our own
    // drive as well, the stretch would keep re-arming and the board would never leave reset

    always_comb begin
        s_d = s_q;
        // pins pass two flops; only the second stage is read
        s_d.run_sync = {s_q.run_sync[0], run_halt_pin};
        s_d.rst_sync = {s_q.rst_sync[0], reset_line_in};
        s_d.irq_sync = {s_q.irq_sync[0], irq_n_pin};
        s_d.nmi_sync = {s_q.nmi_sync[0], nmi_n_pin};

        // ------------------------------------------------------------
        // board reset, stretched so a bouncing switch gives one restart
        // ------------------------------------------------------------
        if (!s_q.rst_sync[1] || !power_on_reset_n) begin
            s_d.reset_cnt = run_halt_pkg::RESET_STRETCH;
            s_d.board_reset = 1'b1;
        end else if (s_q.reset_cnt != '0) begin
            s_d.reset_cnt = s_q.reset_cnt - 4'h1;
        end else begin
            s_d.board_reset = 1'b0;
        end

        // level is only looked at on phase one, like the real input latch
        if (phi1_en) begin
            s_d.run_level = s_q.run_sync[1];
        end

        // ------------------------------------------------------------
        // mode machine
        // ------------------------------------------------------------
        case (s_q.mode)
            run_halt_pkg::ST_RUN: begin
                if (halt_req && at_boundary) begin
                    // the instruction ends this cycle, so stop here instead of running one more
                    s_d.mode = run_halt_pkg::ST_HALT;
                end else if (halt_req) begin
                    s_d.mode = run_halt_pkg::ST_DRAIN;
                end else if (at_boundary && core_wait_insn) begin
                    s_d.mode = run_halt_pkg::ST_WAIT;
                end
            end
            run_halt_pkg::ST_DRAIN: begin
                // finish the instruction in flight before letting go
                if (core_insn_end) begin
                    s_d.mode = run_halt_pkg::ST_HALT;
                end
            end
            run_halt_pkg::ST_HALT: begin
                if (s_q.run_level) begin
                    s_d.mode = run_halt_pkg::ST_RUN;
                end
            end
            run_halt_pkg::ST_WAIT: begin
                if (wake_req) begin
                    s_d.mode = run_halt_pkg::ST_RUN;
                end
            end
            default: begin
                s_d.mode = run_halt_pkg::ST_RUN;
            end
        endcase

        // ------------------------------------------------------------
        // backplane drivers
        // ------------------------------------------------------------
        s_d.pins.bus_available = bus_released;
        s_d.pins.addr_oe = !bus_released;
        s_d.pins.rw_oe = !bus_released;
        s_d.pins.address_valid_strobe = cycle_go;
        s_d.pins.data_oe = cycle_go && cycle_write;
        s_d.pins.read_not_write = !(cycle_go && cycle_write);
        if (cycle_go) begin
            s_d.pins.addr = core_req.addr;
            s_d.pins.data = core_req.wdata;
        end

        // ------------------------------------------------------------
        // read capture
        // ------------------------------------------------------------
        if (read_done) begin
            s_d.rdata = data_in;
        end

        if (!rst_n || s_q.board_reset) begin
            s_d.mode = run_halt_pkg::ST_RUN;
            s_d.pins.address_valid_strobe = 1'b0;
            s_d.pins.data_oe = 1'b0;
            s_d.pins.read_not_write = 1'b1;
        end
    end

    // ------------------------------------------------------------
    // decode
    // ------------------------------------------------------------
    // core may step on while running or while draining the current instruction
    assign running = (s_q.mode == run_halt_pkg::ST_RUN) || (s_q.mode == run_halt_pkg::ST_DRAIN);
    assign bus_released = (s_q.mode == run_halt_pkg::ST_HALT) || (s_q.mode == run_halt_pkg::ST_WAIT);
    assign cycle_go = running && core_req.active;
    assign cycle_write = core_req.write;
    assign read_done = s_q.pins.address_valid_strobe && s_q.pins.read_not_write;
    assign halt_req = !s_q.run_level;
    // either interrupt level ends a wait; both pins idle high
    assign wake_req = !s_q.irq_sync[1] || !s_q.nmi_sync[1];
    assign at_boundary = core_insn_end;

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            s_q <= '0;
            // chains start at the idle high level so reset gives no false request
            s_q.run_sync <= '1;
            s_q.rst_sync <= '1;
            s_q.irq_sync <= '1;
            s_q.nmi_sync <= '1;
            s_q.run_level <= 1'b1;
            s_q.mode <= run_halt_pkg::ST_RUN;
            s_q.reset_cnt <= run_halt_pkg::RESET_STRETCH;
            s_q.board_reset <= 1'b1;
            s_q.pins.read_not_write <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    // the reset line is open drain: it is only ever pulled low, never driven high
    assign core_advance = running && !s_q.board_reset;
    assign core_reset = s_q.board_reset;
    assign core_rdata = s_q.rdata;
    assign pins = s_q.pins;
    assign reset_line_out = 1'b0;
    assign reset_line_oe = s_q.board_reset;
endmodule

// ===== logic/run_halt_pkg.sv
// shared types and constants for the run/halt and bus-release block
package run_halt_pkg;
    localparam int ADDR_W = 16;
    localparam int DATA_W = 8;
    // cycles a board reset is stretched after its cause goes away
    localparam logic [3:0] RESET_STRETCH = 4'hF;
    localparam logic [1:0] CYC_ZERO = 2'h0;

    typedef enum logic [1:0] {
        ST_RUN = 2'b00,
        ST_DRAIN = 2'b01,
        ST_HALT = 2'b11,
        ST_WAIT = 2'b10
    } cpu_mode_t;

    // one bus cycle request from the execution core
    typedef struct packed {
        logic active;
        logic write;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } bus_req_t;

    // pins facing the backplane
    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] data;
        logic addr_oe;
        logic data_oe;
        logic read_not_write;
        logic rw_oe;
        logic address_valid_strobe;
        logic bus_available;
    } bus_pins_t;
endpackage

// ===== verif/run_halt_bus_release_asserts.sv
// port checker for the run/halt block
`timescale 1ns/1ps
module run_halt_bus_release_asserts (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic reset_line_in,
    input wire run_halt_pkg::bus_req_t core_req,
    input wire logic core_insn_end,
    input wire logic core_wait_insn,
    input wire logic core_advance,
    input wire logic core_reset,
    input wire run_halt_pkg::bus_pins_t pins,
    input wire logic reset_line_out,
    input wire logic reset_line_oe
);
    // ---
    // checks
    // ---
    wire logic ba = pins.bus_available;
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);
    chk_halt_strobe: assert property (ba |-> !pins.address_valid_strobe) else $error("strobe");
    chk_halt_float: assert property (ba |-> !(pins.addr_oe | pins.data_oe | pins.rw_oe)
        && pins.read_not_write) else $error("float");
    chk_halt_stall: assert property ($rose(ba) |-> !core_advance) else $error("stall");
    chk_bus_cycle: assert property (core_advance && core_req.active |=> pins.address_valid_strobe
        && pins.read_not_write == !$past(core_req.write)) else $error("cycle");
    chk_insn_whole: assert property (core_advance && !core_insn_end ##1 !core_reset
        |-> core_advance) else $error("stop");
    chk_ext_reset: assert property (!reset_line_in [*3] |-> ##[0:2] core_reset && reset_line_oe
        && !reset_line_out) else $error("reset");
    chk_resume: assert property ($fell(ba) |-> core_advance || core_reset) else $error("resume");
    chk_wait_ba: assert property (core_insn_end && core_wait_insn && core_advance && !core_reset
        |-> ##2 ba) else $error("wait");
    cover property ($rose(ba));
    cover property (core_advance && core_req.active && core_req.write);
    cover property (!reset_line_in && reset_line_oe);
endmodule

// ===== verif/halt_ctrl_model.sv
// run/halt switch, phase-one divider and reset button
`timescale 1ns/1ps
module halt_ctrl_model (
    input wire logic clock,
    input wire logic go,
    input wire logic ext_rst,
    output logic phi1_en = 1'h0,
    output logic run_halt_pin = 1'h1,
    output logic reset_line_in = 1'h1
);
    logic [1:0] ph_q = 2'h0;
    logic go_q = 1'h1;
    logic ext_q = 1'h0;
    // bench controls are taken on the rising edge, so a change at a falling edge never races the pins
    always @(posedge clock) begin
        go_q <= go;
        ext_q <= ext_rst;
    end
    // switch moves only on phase one, so a step is one instruction
    always @(negedge clock) begin
        ph_q <= ph_q + 2'h1;
        phi1_en <= ph_q == 2'h3;
        if (ph_q == 2'h3) run_halt_pin <= go_q;
        reset_line_in <= !ext_q;
    end
endmodule

// ===== verif/run_halt_bus_release_test.sv
// run/halt block bench
`timescale 1ns/1ps
module run_halt_bus_release_test;
    logic clock = 1'h0, rst_n = 1'h0, go = 1'h1, ext_rst = 1'h0, irq_n_pin = 1'h1, nmi_n_pin = 1'h1;
    logic power_on_reset_n = 1'h1, core_insn_end = 1'h0, core_wait_insn = 1'h0, phi1_en, run_halt_pin;
    logic reset_line_in, core_advance, core_reset, reset_line_out, reset_line_oe;
    logic [7:0] data_in = 8'hA5, core_rdata;
    run_halt_pkg::bus_req_t core_req = '0;
    run_halt_pkg::bus_pins_t pins;
    int n_fail = 0, samples_checked = 0, cyc = 0;
    always #10 clock = ~clock;
    halt_ctrl_model model_u (
        .clock(clock),
        .go(go),
        .ext_rst(ext_rst),
        .phi1_en(phi1_en),
        .run_halt_pin(run_halt_pin),
        .reset_line_in(reset_line_in)
    );
    run_halt_bus_release dut_u (
        .clock(clock),
        .rst_n(rst_n),
        .phi1_en(phi1_en),
        .run_halt_pin(run_halt_pin),
        .reset_line_in(reset_line_in),
        .power_on_reset_n(power_on_reset_n),
        .irq_n_pin(irq_n_pin),
        .nmi_n_pin(nmi_n_pin),
        .core_req(core_req),
        .core_insn_end(core_insn_end),
        .core_wait_insn(core_wait_insn),
        .data_in(data_in),
        .core_advance(core_advance),
        .core_reset(core_reset),
        .core_rdata(core_rdata),
        .pins(pins),
        .reset_line_out(reset_line_out),
        .reset_line_oe(reset_line_oe)
    );
    // ---
    // tasks
    // ---
    task automatic wt(input int n);
        repeat (n) @(negedge clock);
    endtask
    task automatic chk(input logic [23:0] g, e);
        samples_checked++;
        if (g !== e) begin
            n_fail++;
            $display("ERROR t=%0t got=%0h exp=%0h", $time, g, e);
        end
    endtask
    task automatic end_sim;
        $display("%0d checks %0d fails", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task automatic t_bus;
        core_req = '{1'h1, 1'h0, 16'h1234, 8'h00}; wt(1); core_req = '{1'h1, 1'h1, 16'h0, 8'h5A};
        chk({pins.address_valid_strobe, pins.read_not_write, pins.data_oe, pins.addr}, {3'h6, 16'h1234});
        wt(1); core_req = '0;
        chk({core_rdata, pins.read_not_write, pins.data_oe, pins.data}, {8'hA5, 2'h1, 8'h5A});
        $display("bus done");
    endtask
    // halt waits for the instruction end, then refuses bus cycles
    task automatic t_halt;
        go = 1'h0; wt(14); chk({pins.bus_available, core_advance}, 2'h1);
        core_insn_end = 1'h1; wt(1); core_insn_end = 1'h0; core_req.active = 1'h1; wt(2);
        chk({pins.bus_available, pins.address_valid_strobe, pins.addr_oe, core_advance}, 4'h8);
        chk({pins.rw_oe, pins.data_oe, pins.read_not_write}, 3'h1);
        core_req.active = 1'h0; go = 1'h1; wt(16);
        chk({pins.bus_available, core_advance, pins.addr_oe, pins.rw_oe}, 4'h7);
        $display("halt done");
    endtask
    task automatic t_wait;
        for (int i = 0; i < 2; i++) begin
            {core_insn_end, core_wait_insn} = 2'h3; wt(1); {core_insn_end, core_wait_insn} = 2'h0; wt(2);
            chk({pins.bus_available, core_advance}, 2'h2);
            {irq_n_pin, nmi_n_pin} = i ? 2'h2 : 2'h1; wt(6);
            chk({pins.bus_available, core_advance}, 2'h1);
            {irq_n_pin, nmi_n_pin} = 2'h3; wt(4);
        end
        $display("wait done");
    endtask
    task automatic t_reset;
        ext_rst = 1'h1; wt(6); chk({core_reset, reset_line_oe, reset_line_out}, 3'h6);
        ext_rst = 1'h0; wt(24); chk({core_reset, reset_line_oe}, 2'h0);
        power_on_reset_n = 1'h0; wt(1); power_on_reset_n = 1'h1; wt(2);
        chk({core_reset, reset_line_oe, reset_line_out}, 3'h6);
        wt(20); chk({core_reset, reset_line_oe}, 2'h0);
        $display("reset done");
    endtask
    initial begin
        wt(10); rst_n = 1'h1; wt(20);
        t_bus; t_halt; t_wait; t_reset; end_sim;
    end
    always @(posedge clock) begin
        cyc <= cyc + 1;
        if (cyc == 1000) begin n_fail++; end_sim; end
    end
endmodule
bind run_halt_bus_release run_halt_bus_release_asserts chk_u (
    .clock(clock),
    .rst_n(rst_n),
    .reset_line_in(reset_line_in),
    .core_req(core_req),
    .core_insn_end(core_insn_end),
    .core_wait_insn(core_wait_insn),
    .core_advance(core_advance),
    .core_reset(core_reset),
    .pins(pins),
    .reset_line_out(reset_line_out),
    .reset_line_oe(reset_line_oe)
);
